// file: csp_pkg.sv
// Constants, types and timing for the charger protection and limit logic.
// Assumes a single 200 MHz clock and comparator levels arriving from analog blocks.
// Overview of operation
// - Flag set while supply-hold loop limits current.
// - Three-bit hold voltage select, 80 mV steps.
// - Ramp current until limit or hold, then hold.
// - Cell above short level loads ceiling default.
// - Other register write locks ceilings until short.
// - Over-ceiling writes store and read the ceiling.
// - Current ceiling uses charge current encoding.
// - Voltage ceiling caps code at 100011 plus n.
// - Foldback temperature reduces current to lowest code.
// - Overheat suspends charging, code 101, pulses pin.
// - Thermal suspend halts validation and retry timer, resumes below foldback.
// - Sleep mode blocks reverse current via switch.
// - Undervoltage stops charging, status 11, code 011.
// - After undervoltage wait retry delay, then restart.
// - Overvoltage opens input switch, code 001, pulse.
// - Overvoltage clears at hysteresis, then revalidate input.
// - Faults give 128 us low pulse, then release.
// - Input must stay valid 30 ms before charging.
package csp_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam longint STAT_PULSE_NS = 128000;
  localparam longint VALID_TIME_MS = 30;
  localparam longint RETRY_TIME_MS = 2000;
  localparam longint RAMP_STEP_NS = 5000;
  localparam logic [31:0] STAT_PULSE_CYCLES = 32'(STAT_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [31:0] VALID_CYCLES = 32'((VALID_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] RETRY_CYCLES = 32'((RETRY_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RAMP_CYCLES = 12'(RAMP_STEP_NS / CLK_PERIOD_NS);

  localparam logic [2:0] IDX_VOLTAGE = 3'h2;
  localparam logic [2:0] IDX_CURRENT = 3'h4;
  localparam logic [2:0] IDX_SOURCE = 3'h5;
  localparam logic [2:0] IDX_SAFETY = 3'h6;

  localparam int VOLT_MSB = 7;
  localparam int VOLT_LSB = 2;
  localparam int CUR_MSB = 6;
  localparam int CUR_LSB = 4;
  localparam int HOLD_FLAG_BIT = 4;
  localparam int HOLD_SEL_MSB = 2;
  localparam int ICEIL_MSB = 6;
  localparam int ICEIL_LSB = 4;
  localparam int VCEIL_MSB = 3;
  localparam int SAFETY_RSVD_BIT = 7;

  localparam logic [7:0] VOLTAGE_RESET = 8'h00;
  localparam logic [7:0] CURRENT_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET = 8'h00;
  localparam logic [7:0] SAFETY_RESET = 8'h40;
  localparam logic [5:0] VCEIL_BASE = 6'h23;
  localparam logic [2:0] FOLDBACK_CODE = 3'h0;

  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_OVP = 3'h1;
  localparam logic [2:0] ERR_SLEEP = 3'h2;
  localparam logic [2:0] ERR_POOR_INPUT = 3'h3;
  localparam logic [2:0] ERR_THERMAL = 3'h5;
  localparam logic [1:0] STAT_READY = 2'h0;
  localparam logic [1:0] STAT_CHARGING = 2'h1;
  localparam logic [1:0] STAT_FAULT = 2'h3;

  typedef struct packed {
    logic vbusAboveFloor;
    logic vbusAboveOvp;
    logic vbusBelowOvpHyst;
    logic vbusBelowSleep;
    logic cellAboveShort;
    logic tempFoldback;
    logic tempShutdown;
    logic holdLoopActive;
    logic inputLimitReached;
  } csp_sense_s;

  localparam int SENSE_W = $bits(csp_sense_s);

  typedef enum logic [4:0] {
    ST_VALIDATE = 5'b00001,
    ST_CHARGE = 5'b00010,
    ST_RETRY = 5'b00100,
    ST_OVP = 5'b01000,
    ST_THERMAL = 5'b10000
  } csp_state_e;

endpackage : csp_pkg

// file: csp_sync.sv
// Three-stage synchroniser with agreement filter for the comparator levels.
// Assumes inputs are asynchronous levels; a change is taken once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module csp_sync
  import csp_pkg::*;
#(
  parameter int W = SENSE_W
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage2Reg;
  logic [W-1:0] stage3Reg;
  logic [W-1:0] syncNext;

  always_comb
  begin
    syncNext = syncOut;
    for (int i = 0; i < W; i++)
    begin
      if (stage2Reg[i] == stage3Reg[i])
      begin
        syncNext[i] = stage3Reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1Reg <= '0;
      stage2Reg <= '0;
      stage3Reg <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      syncOut <= syncNext;
    end
  end

endmodule : csp_sync
`default_nettype wire

// file: csp_timer.sv
// One-shot cycle counter with restart and a hold input.
// Assumes limit is at least one; done is a one-cycle pulse, busy a registered level.
`timescale 1ns/100ps
`default_nettype none
module csp_timer
  import csp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic run,
  input wire logic [31:0] limit,
  output logic busy,
  output logic done
);

  logic [31:0] countReg;
  logic [31:0] countNext;
  logic busyNext;
  logic doneNext;

  always_comb
  begin
    countNext = countReg;
    busyNext = busy;
    doneNext = 1'b0;
    if (start)
    begin
      countNext = '0;
      busyNext = 1'b1;
    end
    else if (busy && run)
    begin
      if (countReg == limit - 32'h1)
      begin
        busyNext = 1'b0;
        doneNext = 1'b1;
      end
      countNext = countReg + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      countReg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      countReg <= countNext;
      busy <= busyNext;
      done <= doneNext;
    end
  end

endmodule : csp_timer
`default_nettype wire

// file: csp_ctrl.sv
// Protection and limit control of a single-cell charger: ceiling registers, input and thermal faults.
// Assumes an external serial slave turns host transfers into single-cycle register strobes on this port.
`timescale 1ns/100ps
`default_nettype none
module csp_ctrl
  import csp_pkg::*;
#(
  parameter logic [31:0] STAT_PULSE_LEN = STAT_PULSE_CYCLES,
  parameter logic [31:0] VALID_LEN = VALID_CYCLES,
  parameter logic [31:0] RETRY_LEN = RETRY_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire csp_sense_s senseIn,
  output logic chargeEnable,
  output logic inputSwitchOn,
  output logic reverseBlockOn,
  output logic currentFoldback,
  output logic [2:0] appliedCurrentCode,
  output logic [5:0] appliedVoltageCode,
  output logic [2:0] holdVoltageSel,
  output logic supplyHoldFlag,
  output logic [2:0] errorCode,
  output logic [1:0] statusBits,
  output logic statPinOut,
  output logic statPinOe
);

  function automatic logic [5:0] clampCode(input logic [5:0] code, input logic [5:0] ceiling);
    clampCode = (code > ceiling) ? ceiling : code;
  endfunction : clampCode

  csp_sense_s sense;
  logic [SENSE_W-1:0] senseSync;
  logic phaseStart;
  logic phaseRun;
  logic phaseDone;
  logic pulseStart;
  logic pulseBusy, pulseDone;
  csp_state_e stateReg, stateNext;

  csp_sync #(.W(SENSE_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(senseIn),
    .syncOut(senseSync)
  );

  assign sense = csp_sense_s'(senseSync);

  // One timer serves input validation and the retry wait, which never overlap.
  csp_timer u_phase (
    .clk(clk),
    .reset_n(reset_n),
    .start(phaseStart),
    .run(phaseRun),
    .limit(stateReg == ST_RETRY ? RETRY_LEN : VALID_LEN),
    .busy(),
    .done(phaseDone)
  );

  csp_timer u_pulse (
    .clk(clk),
    .reset_n(reset_n),
    .start(pulseStart),
    .run(1'b1),
    .limit(STAT_PULSE_LEN),
    .busy(pulseBusy),
    .done(pulseDone)
  );

  logic [7:0] voltageReg, voltageNext;
  logic [7:0] currentReg, currentNext;
  logic [7:0] sourceReg, sourceNext;
  logic [7:0] safetyReg, safetyNext;
  logic lockReg, lockNext;
  logic shortAboveReg;
  logic [7:0] rdataNext;
  logic [5:0] voltCeiling;
  logic [5:0] curCeiling;

  always_comb
  begin
    voltCeiling = VCEIL_BASE + {2'h0, safetyReg[VCEIL_MSB:0]};
    curCeiling = {3'h0, safetyReg[ICEIL_MSB:ICEIL_LSB]};
    voltageNext = voltageReg;
    currentNext = currentReg;
    sourceNext = sourceReg;
    safetyNext = safetyReg;
    lockNext = lockReg;
    rdataNext = regRdata;
    if (!sense.cellAboveShort)
    begin
      lockNext = 1'b0;
    end
    else if (!shortAboveReg)
    begin
      safetyNext = SAFETY_RESET;
      lockNext = 1'b0;
    end
    else if (regWrite)
    begin
      if (regAddr != IDX_SAFETY)
      begin
        lockNext = 1'b1;
      end
      else if (!lockReg)
      begin
        safetyNext = regWdata;
        safetyNext[SAFETY_RSVD_BIT] = 1'b0;
      end
    end
    if (regWrite)
    begin
      unique case (regAddr)
        IDX_VOLTAGE:
        begin
          voltageNext = regWdata;
          voltageNext[VOLT_MSB:VOLT_LSB] = clampCode(regWdata[VOLT_MSB:VOLT_LSB], voltCeiling);
        end
        IDX_CURRENT:
        begin
          currentNext = regWdata;
          currentNext[CUR_MSB:CUR_LSB] = 3'(clampCode({3'h0, regWdata[CUR_MSB:CUR_LSB]}, curCeiling));
        end
        IDX_SOURCE:
        begin
          sourceNext = regWdata;
          sourceNext[HOLD_FLAG_BIT] = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
    if (regRead)
    begin
      unique case (regAddr)
        IDX_VOLTAGE: rdataNext = voltageReg;
        IDX_CURRENT: rdataNext = currentReg;
        IDX_SOURCE:
        begin
          rdataNext = sourceReg;
          rdataNext[HOLD_FLAG_BIT] = supplyHoldFlag;
        end
        IDX_SAFETY: rdataNext = safetyReg;
        default: rdataNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      voltageReg <= VOLTAGE_RESET;
      currentReg <= CURRENT_RESET;
      sourceReg <= SOURCE_RESET;
      safetyReg <= SAFETY_RESET;
      lockReg <= 1'b0;
      shortAboveReg <= 1'b0;
      regRdata <= 8'h00;
    end
    else
    begin
      voltageReg <= voltageNext;
      currentReg <= currentNext;
      sourceReg <= sourceNext;
      safetyReg <= safetyNext;
      lockReg <= lockNext;
      shortAboveReg <= sense.cellAboveShort;
      regRdata <= rdataNext;
    end
  end

  logic [11:0] rampDivReg, rampDivNext;
  logic [2:0] rampReg, rampNext;
  logic sleeping;
  logic inputValid;
  logic [2:0] targetCode;

  always_comb
  begin
    sleeping = sense.vbusBelowSleep && sense.vbusAboveFloor;
    inputValid = sense.vbusAboveFloor && !sense.vbusAboveOvp;
    targetCode = currentReg[CUR_MSB:CUR_LSB];
    stateNext = stateReg;
    unique case (stateReg)
      ST_VALIDATE:
      begin
        if (sense.vbusAboveOvp)
          stateNext = ST_OVP;
        else if (phaseDone && inputValid)
          stateNext = ST_CHARGE;
      end
      ST_CHARGE:
      begin
        if (sense.vbusAboveOvp)
          stateNext = ST_OVP;
        else if (!sense.vbusAboveFloor)
          stateNext = ST_RETRY;
        else if (sense.tempShutdown)
          stateNext = ST_THERMAL;
      end
      ST_RETRY:
      begin
        if (sense.vbusAboveOvp)
          stateNext = ST_OVP;
        else if (phaseDone && sense.vbusAboveFloor)
          stateNext = ST_VALIDATE;
      end
      ST_OVP:
      begin
        if (sense.vbusBelowOvpHyst && !sense.vbusAboveOvp)
          stateNext = ST_VALIDATE;
      end
      ST_THERMAL:
      begin
        if (sense.vbusAboveOvp)
          stateNext = ST_OVP;
        else if (!sense.tempFoldback && !sense.tempShutdown)
          stateNext = ST_CHARGE;
      end
    endcase
    // Validation restarts whenever the input leaves its window; retry re-arms if input stays low.
    phaseStart = (stateNext != stateReg) ||
                 (stateReg == ST_VALIDATE && !inputValid) ||
                 (stateReg == ST_RETRY && phaseDone);
    phaseRun = (stateReg != ST_THERMAL);
    pulseStart = (stateNext != stateReg) &&
                 (stateNext == ST_OVP || stateNext == ST_RETRY || stateNext == ST_THERMAL);
    rampDivNext = (rampDivReg == RAMP_CYCLES - 12'h1) ? 12'h0 : rampDivReg + 12'h1;
    rampNext = rampReg;
    if (stateNext != ST_CHARGE || stateReg != ST_CHARGE)
      rampNext = 3'h0;
    else if (rampReg > targetCode)
      rampNext = targetCode;
    else if (rampDivReg == 12'h0 && !sleeping && rampReg < targetCode &&
             !sense.inputLimitReached && !sense.holdLoopActive)
      rampNext = rampReg + 3'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateReg <= ST_VALIDATE;
      rampDivReg <= 12'h0;
      rampReg <= 3'h0;
      chargeEnable <= 1'b0;
      inputSwitchOn <= 1'b0;
      reverseBlockOn <= 1'b1;
      currentFoldback <= 1'b0;
      appliedCurrentCode <= 3'h0;
      appliedVoltageCode <= 6'h00;
      holdVoltageSel <= 3'h0;
      supplyHoldFlag <= 1'b0;
      errorCode <= ERR_NONE;
      statusBits <= STAT_READY;
      statPinOut <= 1'b0;
      statPinOe <= 1'b0;
    end
    else
    begin
      stateReg <= stateNext;
      rampDivReg <= rampDivNext;
      rampReg <= rampNext;
      chargeEnable <= (stateNext == ST_CHARGE) && !sleeping;
      inputSwitchOn <= (stateNext != ST_OVP);
      reverseBlockOn <= (stateNext != ST_CHARGE) || sleeping;
      currentFoldback <= sense.tempFoldback;
      appliedCurrentCode <= sense.tempFoldback ? FOLDBACK_CODE : rampNext;
      appliedVoltageCode <= voltageReg[VOLT_MSB:VOLT_LSB];
      holdVoltageSel <= sourceReg[HOLD_SEL_MSB:0];
      supplyHoldFlag <= sense.holdLoopActive;
      unique case (stateNext)
        ST_OVP: errorCode <= ERR_OVP;
        ST_RETRY: errorCode <= ERR_POOR_INPUT;
        ST_THERMAL: errorCode <= ERR_THERMAL;
        default: errorCode <= (stateNext == ST_CHARGE && sleeping) ? ERR_SLEEP : ERR_NONE;
      endcase
      if (stateNext == ST_OVP || stateNext == ST_RETRY || stateNext == ST_THERMAL)
        statusBits <= STAT_FAULT;
      else
        statusBits <= (stateNext == ST_CHARGE) ? STAT_CHARGING : STAT_READY;
      statPinOut <= 1'b0;
      statPinOe <= pulseStart || (pulseBusy && !pulseDone);
    end
  end

  chk_hold_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
    sense.holdLoopActive |=> supplyHoldFlag) else $error("hold flag not set");
  chk_hold_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
    !sense.holdLoopActive |=> !supplyHoldFlag) else $error("hold flag not cleared");
  chk_voltage_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    regWrite && regAddr == IDX_VOLTAGE && regWdata[VOLT_MSB:VOLT_LSB] > voltCeiling
    |=> voltageReg[VOLT_MSB:VOLT_LSB] == $past(voltCeiling)) else $error("voltage not clamped");
  chk_current_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    regWrite && regAddr == IDX_CURRENT
    |=> currentReg[CUR_MSB:CUR_LSB] <= $past(safetyReg[ICEIL_MSB:ICEIL_LSB])) else $error("current over ceiling");
  chk_safety_locked: assert property (@(posedge clk) disable iff (!reset_n)
    lockReg && sense.cellAboveShort && shortAboveReg
    |=> $stable(safetyReg)) else $error("locked ceiling changed");
  chk_ovp_outputs: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg == ST_OVP |-> !inputSwitchOn && !chargeEnable && errorCode == 3'h1 && statusBits == 2'h3)
    else $error("overvoltage outputs wrong");
  chk_uv_outputs: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(stateReg == ST_RETRY) |-> errorCode == 3'h3 && statusBits == 2'h3 && statPinOe && !chargeEnable)
    else $error("undervoltage outputs wrong");
  chk_thermal_hold: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg == ST_THERMAL |-> !chargeEnable && errorCode == 3'h5 && !phaseRun)
    else $error("thermal suspend wrong");
  chk_stat_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(statPinOe) |-> statPinOe[*8] ##0 !statPinOut) else $error("fault pulse too short");
  chk_foldback_code: assert property (@(posedge clk) disable iff (!reset_n)
    sense.tempFoldback |=> currentFoldback && appliedCurrentCode == 3'h0) else $error("foldback missing");
  chk_sleep_block: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg == ST_CHARGE && sleeping |=> reverseBlockOn || stateReg != ST_CHARGE) else $error("sleep not blocking");
  chk_valid_before: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(stateReg == ST_CHARGE) && $past(stateReg == ST_VALIDATE) |-> $past(phaseDone))
    else $error("charge without validation");

  cov_charge_start: cover property (@(posedge clk) disable iff (!reset_n) $rose(stateReg == ST_CHARGE));
  cov_ovp_cycle: cover property (@(posedge clk) disable iff (!reset_n)
    stateReg == ST_OVP ##1 stateReg == ST_VALIDATE);
  cov_retry_entry: cover property (@(posedge clk) disable iff (!reset_n) $rose(stateReg == ST_RETRY));
  cov_ceiling_load: cover property (@(posedge clk) disable iff (!reset_n)
    regWrite && regAddr == IDX_SAFETY && !lockReg);

endmodule : csp_ctrl
`default_nettype wire

// file: csp_analog_model.sv
// Behavioural model of the analog comparators around the charger protection logic.
// Assumes the bench sets supply, cell and die levels; levels update on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module csp_analog_model
  import csp_pkg::*;
#(
  parameter int FLOOR_MV = 4400,
  parameter int OVP_MV = 6500,
  parameter int HYST_MV = 150,
  parameter int SLEEP_MV = 100,
  parameter int SHORT_MV = 2000,
  parameter int FOLD_C = 120,
  parameter int TRIP_C = 150
)
(
  input wire logic clk,
  input wire logic [15:0] vbusMv,
  input wire logic [15:0] cellMv,
  input wire logic [7:0] tempC,
  input wire logic limitReq,
  input wire logic chargeOn,
  input wire logic [2:0] holdSel,
  output var csp_sense_s senseOut
);
  int holdMv;

  // Hold level steps 80 mV from 4.213 V.
  assign holdMv = 4213 + 80 * int'(holdSel);

  // The hold loop only limits while current flows, so it is gated by the charge enable.
  always @(negedge clk)
  begin
    senseOut.vbusAboveFloor <= int'(vbusMv) > FLOOR_MV;
    senseOut.vbusAboveOvp <= int'(vbusMv) > OVP_MV;
    senseOut.vbusBelowOvpHyst <= int'(vbusMv) < OVP_MV - HYST_MV;
    senseOut.vbusBelowSleep <= int'(vbusMv) < int'(cellMv) + SLEEP_MV;
    senseOut.cellAboveShort <= int'(cellMv) > SHORT_MV;
    senseOut.tempFoldback <= int'(tempC) >= FOLD_C;
    senseOut.tempShutdown <= int'(tempC) > TRIP_C;
    senseOut.holdLoopActive <= chargeOn && int'(vbusMv) <= holdMv;
    senseOut.inputLimitReached <= limitReq;
  end
endmodule : csp_analog_model
`default_nettype wire

// file: tb_csp_ctrl.sv
// Self-checking bench for the charger protection logic with a comparator model.
// Assumes short timing parameters; inputs change on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module tb_csp_ctrl
  import csp_pkg::*;
;
  localparam logic [31:0] PULSE = 32'h14;
  localparam logic [31:0] VALID = 32'h32;
  localparam logic [31:0] RETRY = 32'h50;
  logic clk, reset_n, regWrite, regRead, rdSeen;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata;
  csp_sense_s senseIn;
  logic chargeEnable, inputSwitchOn, reverseBlockOn, currentFoldback, supplyHoldFlag, statPinOut, statPinOe;
  logic [2:0] appliedCurrentCode, holdVoltageSel, errorCode;
  logic [5:0] appliedVoltageCode, code, vmax;
  logic [1:0] statusBits;
  logic [2:0] cur;
  logic [15:0] vbusMv, cellMv;
  logic [7:0] tempC;
  logic limitReq;
  logic [7:0] expQ[$], mskQ[$];
  int fails, cmp_count, cyc, n;

  csp_ctrl #(.STAT_PULSE_LEN(PULSE), .VALID_LEN(VALID), .RETRY_LEN(RETRY)) DUT (.clk(clk), .reset_n(reset_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .senseIn(senseIn), .chargeEnable(chargeEnable), .inputSwitchOn(inputSwitchOn), .reverseBlockOn(reverseBlockOn),
    .currentFoldback(currentFoldback), .appliedCurrentCode(appliedCurrentCode),
    .appliedVoltageCode(appliedVoltageCode), .holdVoltageSel(holdVoltageSel), .supplyHoldFlag(supplyHoldFlag),
    .errorCode(errorCode), .statusBits(statusBits), .statPinOut(statPinOut), .statPinOe(statPinOe));

  csp_analog_model ana (.clk(clk), .vbusMv(vbusMv), .cellMv(cellMv), .tempC(tempC), .limitReq(limitReq),
    .chargeOn(chargeEnable), .holdSel(holdVoltageSel), .senseOut(senseIn));

  always #2.5 clk = ~clk;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk, input string what);
    cmp_count++;
    if ((got & msk) !== (exp & msk))
    begin
      fails++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask : idle

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
  endtask : reg_rd

  task automatic wait_ce(output int k);
    k = 0;
    while (chargeEnable !== 1'b1 && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
  endtask : wait_ce

  // Counts the cycles in which the status pin is pulled low.
  task automatic pulse();
    int w;
    int len;
    w = 0;
    len = 0;
    while (statPinOe !== 1'b1 && w < 300)
    begin
      @(negedge clk);
      w++;
    end
    chk(8'(statPinOut), 8'h00, 8'h01, "pin level");
    while (statPinOe === 1'b1 && len < 300)
    begin
      @(negedge clk);
      len++;
    end
    chk(8'(len), 8'(PULSE + 32'h1), 8'hFF, "pulse length");
  endtask : pulse

  always @(posedge clk) rdSeen <= regRead;

  always @(negedge clk)
    if (rdSeen === 1'b1)
      chk(regRdata, expQ.pop_front(), mskQ.pop_front(), "read data");

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    vbusMv = 16'h0000;
    cellMv = 16'h0E74;
    tempC = 8'h19;
    limitReq = 1'b0;
    void'($urandom(32'h35ED));
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    idle(10);
    reg_rd(IDX_VOLTAGE, VOLTAGE_RESET, 8'hFF);
    reg_rd(IDX_CURRENT, CURRENT_RESET, 8'hFF);
    reg_rd(IDX_SOURCE, SOURCE_RESET, 8'hFF);
    reg_rd(IDX_SAFETY, SAFETY_RESET, 8'hFF);
    reg_rd(3'h7, 8'h00, 8'hFF);
    reg_wr(IDX_SAFETY, 8'hB5);
    reg_wr(IDX_SAFETY, 8'hB5);
    reg_rd(IDX_SAFETY, 8'h35, 8'hFF);
    vmax = VCEIL_BASE + 6'h05;
    for (int i = 0; i < 10; i++)
    begin
      code = (i == 0) ? vmax : (i == 1) ? vmax + 6'h01 : (i == 2) ? 6'h3F : 6'($urandom_range(63));
      cur = (i == 0) ? 3'h7 : (i == 1) ? 3'h3 : 3'($urandom_range(7));
      reg_wr(IDX_VOLTAGE, {code, 2'b00});
      reg_rd(IDX_VOLTAGE, {(code > vmax) ? vmax : code, 2'b00}, 8'hFC);
      chk(8'(appliedVoltageCode), 8'((code > vmax) ? vmax : code), 8'h3F, "voltage code");
      reg_wr(IDX_CURRENT, {1'b0, cur, 4'h0});
      reg_rd(IDX_CURRENT, {1'b0, (cur > 3'h3) ? 3'h3 : cur, 4'h0}, 8'h70);
    end
    for (int s = 0; s < 8; s++)
    begin
      reg_wr(IDX_SOURCE, 8'h10 | 8'(s));
      reg_rd(IDX_SOURCE, 8'(s), 8'h17);
      chk(8'(holdVoltageSel), 8'(s), 8'h07, "hold select");
    end
    reg_wr(IDX_CURRENT, 8'h30);
    reg_wr(IDX_SAFETY, 8'h77);
    reg_rd(IDX_SAFETY, 8'h35, 8'hFF);
    cellMv = 16'h03E8;
    idle(10);
    cellMv = 16'h0E74;
    idle(10);
    reg_rd(IDX_SAFETY, SAFETY_RESET, 8'hFF);
    vbusMv = 16'h1388;
    wait_ce(n);
    chk(8'(n >= VALID && n <= VALID + 12), 8'h01, 8'h01, "validate time");
    n = 0;
    while (appliedCurrentCode !== 3'h3 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    chk(8'(appliedCurrentCode), 8'h03, 8'h07, "ramp end");
    vbusMv = 16'h125C;
    idle(10);
    reg_rd(IDX_SOURCE, 8'h17, 8'h17);
    chk(8'(supplyHoldFlag), 8'h01, 8'h01, "hold flag");
    vbusMv = 16'h1388;
    idle(10);
    reg_rd(IDX_SOURCE, 8'h07, 8'h17);
    vbusMv = 16'h1B58;
    pulse();
    chk({errorCode, statusBits, inputSwitchOn, chargeEnable, 1'b0}, {ERR_OVP, STAT_FAULT, 3'h0}, 8'hFE, "ovp");
    vbusMv = 16'h1900;
    idle(20);
    chk(8'(errorCode), 8'(ERR_OVP), 8'h07, "ovp hold");
    vbusMv = 16'h1388;
    wait_ce(n);
    chk(8'(n >= VALID && n <= VALID + 12), 8'h01, 8'h01, "revalidate");
    tempC = 8'h82;
    idle(10);
    chk({currentFoldback, appliedCurrentCode}, {1'b1, FOLDBACK_CODE}, 8'h0F, "foldback");
    tempC = 8'hA0;
    pulse();
    chk({errorCode, statusBits, chargeEnable}, {ERR_THERMAL, STAT_FAULT, 1'b0}, 8'h3F, "thermal");
    tempC = 8'h82;
    idle(20);
    chk(8'(errorCode), 8'(ERR_THERMAL), 8'h07, "thermal hold");
    // A source already at its input limit must keep the restarted ramp at its lowest step.
    limitReq = 1'b1;
    tempC = 8'h19;
    wait_ce(n);
    chk(8'(n <= 10), 8'h01, 8'h01, "thermal resume");
    idle(2100);
    chk(8'(appliedCurrentCode), 8'h00, 8'h07, "ramp held");
    limitReq = 1'b0;
    cellMv = 16'h1130;
    vbusMv = 16'h1162;
    idle(10);
    chk({errorCode, chargeEnable, reverseBlockOn, statPinOe}, {ERR_SLEEP, 3'h2}, 8'h3F, "sleep");
    cellMv = 16'h0E74;
    vbusMv = 16'h1388;
    wait_ce(n);
    vbusMv = 16'h0BB8;
    pulse();
    chk({errorCode, statusBits, chargeEnable}, {ERR_POOR_INPUT, STAT_FAULT, 1'b0}, 8'h3F, "undervoltage");
    vbusMv = 16'h1388;
    wait_ce(n);
    n = n + int'(PULSE) + 1;
    chk(8'(n >= RETRY + VALID && n <= RETRY + VALID + 14), 8'h01, 8'h01, "retry time");
    idle(5);
    end_of_test();
  end
endmodule : tb_csp_ctrl
`default_nettype wire
